// ---- backplane_monitor.sv ----
// Power monitor model: pulls the reset and test-select lines low.
// Assumes pull-ups on those lines in the bench.
`timescale 1ns/1ps
module backplane_monitor #(
  parameter int HOLD_CYCLES = 12
) (
  input  wire logic ref_clk,
  output logic      mon_reset_pull,
  output logic      mon_low_pull,
  output logic      mon_high_pull
);
  initial {mon_reset_pull, mon_low_pull, mon_high_pull} = 3'h0;
  // Levels set with the reset pull, reset held, levels kept past release
  task automatic pulse_reset(input logic [1:0] mode, input int slow);
    @(posedge ref_clk);
    #1 {mon_high_pull, mon_low_pull} = ~mode;
    mon_reset_pull = 1'b1;
    repeat (HOLD_CYCLES + slow) @(posedge ref_clk);
    #1 mon_reset_pull = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 {mon_high_pull, mon_low_pull} = 2'h0;
  endtask
endmodule // backplane_monitor

// ---- backplane_reset_test_utility.sv ----
// Backplane utility logic of one board: backplane clock, line clock,
// reset and test-select capture, self-test sequencing, failure line.
// Assumes all inputs are sampled on ref_clk; open-collector lines are
// resolved outside from the *_oe_n enables.
// Summary of operation
// - Backplane clock free-running, ungated, 16 MHz, about half duty.
// - Fixed delays are counted in backplane clock ticks.
// - No phase relation assumed between backplane clock and other bus timing.
// - Line clock edges follow mains zero crossings within 95 or 115 us.
// - Reset and test-select lines are only pulled low or released.
// - Failure line pulled low from power-up until operation: passed self test, HH capture or test register write.
// - Board without self test holds failure line until test register write.
// - Reset rising edge captures both test-select levels as test mode.
// - Modes: HH operate, HL debug, LH long test, LL short test <=2 s.
// - Failure line held low after any test failure until the next reset.
// - In operation a detected fault asserts the failure line again.
// - Reserved backplane lines are neither driven nor read.
`timescale 1ns/1ps

module backplane_reset_test_utility
  import backplane_utility_pkg::*;
#(
  parameter int unsigned SHORT_TEST_LIMIT = SHORT_TEST_TICKS,
  parameter int unsigned RESET_HOLD_LIMIT = RESET_HOLD_TICKS
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  output logic            backplane_clock,
  input  wire logic       mains_polarity,
  output logic            line_frequency_clock,
  input  wire logic       backplane_reset_line_in,
  output logic            backplane_reset_line_out,
  output logic            backplane_reset_line_oe_n,
  input  wire logic       test_select_low_in,
  output logic            test_select_low_out,
  output logic            test_select_low_oe_n,
  input  wire logic       test_select_high_in,
  output logic            test_select_high_out,
  output logic            test_select_high_oe_n,
  input  wire logic       board_failure_line_in,
  output logic            board_failure_line_out,
  output logic            board_failure_line_oe_n,
  input  wire logic       manual_reset_req,
  input  wire logic [1:0] requested_mode,
  input  wire logic       self_test_capable,
  input  wire logic       self_test_done,
  input  wire logic       self_test_pass,
  input  wire logic       test_register_write,
  input  wire logic       fault_detected,
  output logic            self_test_start,
  output logic [1:0]      self_test_mode,
  output logic            operating_program,
  output logic            debug_mode,
  output logic            test_failed,
  output logic            system_failure_seen
);

  localparam logic [TIMER_W-1:0] SHORT_LIM = TIMER_W'(SHORT_TEST_LIMIT);
  localparam logic [TIMER_W-1:0] HOLD_LIM  = TIMER_W'(RESET_HOLD_LIMIT);
  localparam logic [TIMER_W-1:0] TIMER_MAX = '1;

  ////////////////////////////////////////////////////////////////////////////
  // Start value; synchronisers and edge detector begin at the idle line level
  localparam util_state_t START_VALUE = '{
    nco:          '0,
    sync1:        5'h17,
    sync2:        5'h17,
    rst_prev:     1'h1,
    line_clk:     1'h0,
    fail_seen:    1'h0,
    mode:         2'h0,
    st:           ST_RESET,
    test_timer:   '0,
    fail_release: 1'h0,
    test_start:   1'h0,
    test_failed:  1'h0,
    operating:    1'h0,
    debug:        1'h0,
    rst_drive:    1'h0,
    tsel_drive:   1'h0,
    req_mode:     2'h3,
    hold_timer:   '0
  };

  util_state_t cur_ff;
  util_state_t nxt_ff;
  logic        tick;
  logic        rst_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode at the reset rising edge
  function automatic seq_state_t mode_state(input logic [1:0] mode,
                                            input logic       capable);
    seq_state_t s;
    s = ST_OPERATE;
    if (!capable) begin
      s = ST_WAIT_WRITE;
    end else begin
      unique case (mode)
        MODE_NO_TEST: s = ST_OPERATE;
        MODE_DEBUG:   s = ST_DEBUG;
        MODE_LONG:    s = ST_LONG_TEST;
        MODE_SHORT:   s = ST_SHORT_TEST;
      endcase
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Saturating step of a tick counter
  function automatic logic [TIMER_W-1:0] sat_inc(input logic [TIMER_W-1:0] v,
                                                 input logic               step);
    logic [TIMER_W-1:0] r;
    r = v;
    if (step && (v != TIMER_MAX)) begin
      r = v + 1'b1;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // States with a running self test
  function automatic logic is_test_state(input seq_state_t s);
    return (s == ST_SHORT_TEST) || (s == ST_LONG_TEST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Outcome of a finished self test
  function automatic seq_state_t verdict_state(input logic pass);
    seq_state_t s;
    s = ST_FAILED;
    if (pass) begin
      s = ST_OPERATE;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_ff = cur_ff;

    // Backplane clock from a phase accumulator, never stopped
    nxt_ff.nco = cur_ff.nco + NCO_INC;
    tick       = nxt_ff.nco[NCO_W-1] & ~cur_ff.nco[NCO_W-1];

    // Two-stage synchronisers; backplane inputs are asynchronous
    nxt_ff.sync1 = {board_failure_line_in, mains_polarity, test_select_high_in,
                    test_select_low_in, backplane_reset_line_in};
    nxt_ff.sync2 = cur_ff.sync1;

    // Edge detect and line mirrors, second stage only
    nxt_ff.rst_prev  = cur_ff.sync2[SI_RESET];
    nxt_ff.line_clk  = cur_ff.sync2[SI_MAINS];
    nxt_ff.fail_seen = ~cur_ff.sync2[SI_FAIL];
    rst_rise         = cur_ff.sync2[SI_RESET] & ~cur_ff.rst_prev;

    // Test timer in backplane ticks
    nxt_ff.test_start = 1'b0;
    nxt_ff.test_timer = sat_inc(cur_ff.test_timer, tick);

    // Self-test sequencer
    if (!cur_ff.sync2[SI_RESET]) begin
      nxt_ff.st = ST_RESET;
    end else if (rst_rise) begin
      nxt_ff.mode       = {cur_ff.sync2[SI_TSEL_HIGH], cur_ff.sync2[SI_TSEL_LOW]};
      nxt_ff.st         = mode_state(nxt_ff.mode, self_test_capable);
      nxt_ff.test_timer = '0;
      nxt_ff.test_start = is_test_state(nxt_ff.st);
    end else begin
      unique case (cur_ff.st)
        ST_SHORT_TEST: begin
          if (self_test_done) begin
            nxt_ff.st = verdict_state(self_test_pass);
          end else if (cur_ff.test_timer >= SHORT_LIM) begin
            nxt_ff.st = ST_FAILED;
          end
        end

        ST_LONG_TEST: begin
          if (self_test_done) begin
            nxt_ff.st = verdict_state(self_test_pass);
          end
        end

        ST_DEBUG: begin
          if (test_register_write) begin
            nxt_ff.st = ST_OPERATE;
          end
        end

        ST_WAIT_WRITE: begin
          if (test_register_write) begin
            nxt_ff.st = ST_OPERATE;
          end
        end

        ST_OPERATE: begin
          if (fault_detected) begin
            nxt_ff.st = ST_FAILED;
          end
        end

        ST_FAILED: begin
          nxt_ff.st = ST_FAILED;
        end

        ST_RESET: begin
          nxt_ff.st = ST_RESET;
        end

        default: begin
          nxt_ff.st = ST_FAILED;
        end
      endcase
    end

    // Failure line released only in operation, sticky fail until reset
    nxt_ff.fail_release = (nxt_ff.st == ST_OPERATE);
    nxt_ff.operating    = (nxt_ff.st == ST_OPERATE);
    nxt_ff.debug        = (nxt_ff.st == ST_DEBUG);
    nxt_ff.test_failed  = (nxt_ff.st == ST_FAILED);

    // Local reset driver with minimum hold and test-select setup
    if (!cur_ff.rst_drive) begin
      if (manual_reset_req) begin
        nxt_ff.rst_drive  = 1'b1;
        nxt_ff.tsel_drive = 1'b1;
        nxt_ff.req_mode   = requested_mode;
        nxt_ff.hold_timer = '0;
      end else if (cur_ff.tsel_drive && cur_ff.sync2[SI_RESET]) begin
        nxt_ff.tsel_drive = 1'b0;
        nxt_ff.req_mode   = 2'h3;
      end
    end else begin
      nxt_ff.hold_timer = sat_inc(cur_ff.hold_timer, tick);
      if (cur_ff.hold_timer > HOLD_LIM && !manual_reset_req) begin
        nxt_ff.rst_drive = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cur_ff <= START_VALUE;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock outputs
  assign backplane_clock           = cur_ff.nco[NCO_W-1];
  assign line_frequency_clock      = cur_ff.line_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Open-collector lines only pull low or float, reserved lines absent
  assign backplane_reset_line_out  = LINE_LOW;
  assign backplane_reset_line_oe_n = ~cur_ff.rst_drive;
  assign test_select_low_out       = LINE_LOW;
  assign test_select_low_oe_n      = cur_ff.req_mode[0];
  assign test_select_high_out      = LINE_LOW;
  assign test_select_high_oe_n     = cur_ff.req_mode[1];
  assign board_failure_line_out    = LINE_LOW;
  assign board_failure_line_oe_n   = cur_ff.fail_release;

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs
  assign self_test_start           = cur_ff.test_start;
  assign self_test_mode            = cur_ff.mode;
  assign operating_program         = cur_ff.operating;
  assign debug_mode                = cur_ff.debug;
  assign test_failed               = cur_ff.test_failed;
  assign system_failure_seen       = cur_ff.fail_seen;

endmodule // backplane_reset_test_utility

// ---- backplane_reset_test_utility_bench.sv ----
// Bench: monitor model drives the lines, a reference model checks results.
// Assumes the bound checker and the monitor model beside the design.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module backplane_reset_test_utility_bench import backplane_utility_pkg::*;;
  logic ref_clk, nrst, mains_polarity, manual_reset_req, self_test_capable, self_test_done;
  logic self_test_pass, test_register_write, fault_detected, other_fail, backplane_clock;
  logic line_frequency_clock, backplane_reset_line_out, backplane_reset_line_oe_n;
  logic test_select_low_out, test_select_low_oe_n, test_select_high_out, debug_mode;
  logic test_select_high_oe_n, board_failure_line_out, board_failure_line_oe_n;
  logic self_test_start, operating_program, test_failed, system_failure_seen;
  logic mon_reset_pull, mon_low_pull, mon_high_pull;
  logic [1:0] requested_mode, self_test_mode, m;
  logic mains_q[$];
  int   mismatches, comparisons, cycles, starts, n;
  wire logic backplane_reset_line_in = !(mon_reset_pull || !backplane_reset_line_oe_n);
  wire logic test_select_low_in = !(mon_low_pull || !test_select_low_oe_n);
  wire logic test_select_high_in = !(mon_high_pull || !test_select_high_oe_n);
  wire logic board_failure_line_in = !(other_fail || !board_failure_line_oe_n);
  wire logic [2:0] st = {operating_program, debug_mode, board_failure_line_oe_n};
  backplane_reset_test_utility #(.SHORT_TEST_LIMIT(20), .RESET_HOLD_LIMIT(10)) dut (.*);
  backplane_monitor #(.HOLD_CYCLES(12)) monitor (.*);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    starts += int'(self_test_start === 1'b1);
    mains_q.push_back(mains_polarity);
    if (mains_q.size() > 3) void'(mains_q.pop_front());
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  // Expected {operating, debug, failure released} just after capture
  function automatic logic [2:0] after_capture(input logic [1:0] md, input logic cap);
    return (!cap || !md[1]) ? 3'h0 : (md[0] ? 3'h5 : 3'h2);
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    {mains_polarity, manual_reset_req, self_test_done, self_test_pass} = 4'h0;
    {test_register_write, fault_detected, other_fail, requested_mode} = 5'h00;
    self_test_capable = 1'b1;
    void'($urandom(30292));
    tick(6);
    nrst = 1'b1;
    tick(1);
    `CHK("power-up", 2'h0, {board_failure_line_oe_n, operating_program})
    $display("test power-up done");
    for (int i = 0; i < 5; i++) begin
      m = (i == 4) ? 2'h3 : 2'(i);
      self_test_capable = (i != 4);
      starts = 0;
      monitor.pulse_reset(m, $urandom_range(0, 9));
      `CHK("mode", m, self_test_mode)
      `CHK("release", after_capture(m, self_test_capable), st)
      `CHK("starts", int'(self_test_capable && !m[1]), starts)
      if (self_test_capable && !m[1]) begin
        self_test_pass = 1'($urandom_range(0, 1));
        strobe(self_test_done);
        `CHK("verdict", {self_test_pass, !self_test_pass}, {st[0], test_failed})
      end else if (!st[2]) begin
        strobe(test_register_write);
        `CHK("write", 3'h5, st)
      end
      $display("test mode %0d done", i);
    end
    self_test_capable = 1'b1;
    monitor.pulse_reset(MODE_SHORT, 0);
    tick(130);
    `CHK("early", 1'b0, test_failed)
    tick(60);
    `CHK("late", 2'h1, {board_failure_line_oe_n, test_failed})
    $display("test short timeout done");
    monitor.pulse_reset(MODE_NO_TEST, 0);
    other_fail = 1'b1;
    tick(4);
    `CHK("other board", 1'b1, system_failure_seen)
    other_fail = 1'b0;
    strobe(fault_detected);
    `CHK("fault", 2'h1, {board_failure_line_oe_n, test_failed})
    strobe(test_register_write);
    `CHK("sticky", 1'b1, test_failed)
    $display("test fault done");
    requested_mode = 2'($urandom_range(0, 3));
    strobe(manual_reset_req);
    `CHK("drive", requested_mode, {test_select_high_in, test_select_low_in})
    for (n = 0; backplane_reset_line_in === 1'b0 && n < 400; n++) tick(1);
    `CHK("held", 1'b1, n >= 78)
    tick(6);
    `CHK("own mode", requested_mode, self_test_mode)
    $display("test manual reset done");
    repeat (40) begin
      mains_polarity = 1'($urandom_range(0, 1));
      tick(1);
      `CHK("line clock", mains_q[0], line_frequency_clock)
    end
    $display("test line clock done");
    n = 0;
    for (int k = 0; k < 250; k++) begin
      m[0] = backplane_clock;
      tick(1);
      n += int'(backplane_clock === 1'b1 && m[0] === 1'b0);
    end
    `CHK("clock edges", 1'b1, n >= 31 && n <= 33)
    `CHK("pull levels", 4'h0, {backplane_reset_line_out, test_select_low_out, test_select_high_out, board_failure_line_out})
    $display("test backplane clock done");
    conclude();
  end
endmodule // backplane_reset_test_utility_bench

// ---- backplane_utility_pkg.sv ----
// Constants, states and the state record of the backplane utility block.
// Assumes a single 125 MHz reference clock and a synchronous active-low reset.
package backplane_utility_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock rates and backplane clock synthesis
  localparam int unsigned REF_CLK_HZ       = 125_000_000;
  localparam int unsigned BACKPLANE_CLK_HZ = 16_000_000;
  localparam int unsigned NCO_W            = 32;
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'(((64'(BACKPLANE_CLK_HZ) << NCO_W) + 64'(REF_CLK_HZ / 2)) / 64'(REF_CLK_HZ));

  ////////////////////////////////////////////////////////////////////////////
  // Timing, counted in backplane clock ticks
  localparam int unsigned SHORT_TEST_MAX_MS = 2000;
  localparam int unsigned RESET_HOLD_MIN_MS = 200;
  localparam int unsigned TICKS_PER_MS      = BACKPLANE_CLK_HZ / 1000;
  localparam int unsigned SHORT_TEST_TICKS  = TICKS_PER_MS * SHORT_TEST_MAX_MS;
  localparam int unsigned RESET_HOLD_TICKS  = TICKS_PER_MS * RESET_HOLD_MIN_MS;
  localparam int unsigned TIMER_W           = 25;

  ////////////////////////////////////////////////////////////////////////////
  // Test modes as {test_select_high, test_select_low} line levels
  localparam logic [1:0] MODE_NO_TEST = 2'h3;
  localparam logic [1:0] MODE_DEBUG   = 2'h2;
  localparam logic [1:0] MODE_LONG    = 2'h1;
  localparam logic [1:0] MODE_SHORT   = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser bit positions
  localparam int unsigned SYNC_W       = 5;
  localparam int unsigned SI_RESET     = 0;
  localparam int unsigned SI_TSEL_LOW  = 1;
  localparam int unsigned SI_TSEL_HIGH = 2;
  localparam int unsigned SI_MAINS     = 3;
  localparam int unsigned SI_FAIL      = 4;

  localparam logic LINE_LOW = 1'b0;

  typedef enum logic [2:0] {
    ST_RESET      = 3'b000,
    ST_SHORT_TEST = 3'b001,
    ST_LONG_TEST  = 3'b010,
    ST_DEBUG      = 3'b011,
    ST_OPERATE    = 3'b100,
    ST_FAILED     = 3'b101,
    ST_WAIT_WRITE = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic [NCO_W-1:0]   nco;
    logic [SYNC_W-1:0]  sync1;
    logic [SYNC_W-1:0]  sync2;
    logic               rst_prev;
    logic               line_clk;
    logic               fail_seen;
    logic [1:0]         mode;
    seq_state_t         st;
    logic [TIMER_W-1:0] test_timer;
    logic               fail_release;
    logic               test_start;
    logic               test_failed;
    logic               operating;
    logic               debug;
    logic               rst_drive;
    logic               tsel_drive;
    logic [1:0]         req_mode;
    logic [TIMER_W-1:0] hold_timer;
  } util_state_t;

  localparam util_state_t UTIL_RESET_VALUE = '0;

endpackage

// ---- backplane_utility_properties.sv ----
// Checker: reset, test capture and failure line timing at the ports.
// Assumes binding onto backplane_reset_test_utility, one clock domain.
`timescale 1ns/1ps
module backplane_utility_checker
  import backplane_utility_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       backplane_clock,
  input wire logic       backplane_reset_line_in,
  input wire logic       test_select_low_in,
  input wire logic       test_select_high_in,
  input wire logic       board_failure_line_oe_n,
  input wire logic       self_test_capable,
  input wire logic       fault_detected,
  input wire logic       self_test_start,
  input wire logic [1:0] self_test_mode,
  input wire logic       operating_program,
  input wire logic       test_failed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  // Reset release with steady test lines
  sequence s_quiet_rise;
    ($stable({test_select_high_in, test_select_low_in}) && !backplane_reset_line_in)[*4]
    ##1 ($stable({test_select_high_in, test_select_low_in}) && backplane_reset_line_in)[*6];
  endsequence
  property p_pwr_fail; $rose(nrst) |-> !board_failure_line_oe_n; endproperty
  a_pwr_fail: assert property (p_pwr_fail) else $error("failure line free at power-up");
  property p_hold; (!backplane_reset_line_in)[*4] |=> !board_failure_line_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("failure line free in reset");
  property p_mode; s_quiet_rise |-> self_test_mode == {test_select_high_in, test_select_low_in};
  endproperty
  a_mode: assert property (p_mode) else $error("test mode not captured");
  property p_no_test; s_quiet_rise ##0 (self_test_capable
    && {test_select_high_in, test_select_low_in} == MODE_NO_TEST)
    |-> operating_program && board_failure_line_oe_n; endproperty
  a_no_test: assert property (p_no_test) else $error("no-test mode not entered");
  property p_start; self_test_start |-> !self_test_mode[1] ##1 !self_test_start; endproperty
  a_start: assert property (p_start) else $error("bad test start");
  property p_failed; test_failed |-> !board_failure_line_oe_n && !operating_program; endproperty
  a_failed: assert property (p_failed) else $error("failure line free after failure");
  property p_fault; backplane_reset_line_in[*4] ##0 (operating_program && fault_detected)
    |=> test_failed && !board_failure_line_oe_n; endproperty
  a_fault: assert property (p_fault) else $error("fault not flagged");
  property p_bp_clk; $changed(backplane_clock)
    |=> $stable(backplane_clock)[*2] ##[1:2] $changed(backplane_clock); endproperty
  a_bp_clk: assert property (p_bp_clk) else $error("backplane clock half period");
endmodule // backplane_utility_checker
bind backplane_reset_test_utility backplane_utility_checker u_chk (.*);
